// file: common/qbc_defines.vh
// Purpose: Constants for the burst-of-four command port.
// Assumes: x18 data beats, 16 word locations.
// Notes:   Included by the design file and the bench files.
// Overview of operation
// - A low fetch command at a master clock rise, unless the slot before took a read, is a read whatever the store command says.
// - Fetch high with store low at a master clock rise starts a burst-of-four write.
// - Both commands high make a no-operation and the location bus is ignored.
// - Read beats leave aligned to echo clock edges at n+3, n+3.5, n+4 and n+4.5.
// - A write two cycles after a write is held pending while the last two beats are taken; a write right after one is ignored.
// - After a read the next command slot carries the third and fourth read beats.
// - With termination off, read data floats for one cycle three cycles after a lone NOP or write.
// - With termination on, read data is driven low for that cycle instead.
// - Output valid changes on the falling phase together with the second beat of a cycle.
`ifndef QBC_DEFINES_VH
`define QBC_DEFINES_VH

`define QBC_DATA_W      18
`define QBC_LOC_W       4
`define QBC_WORDS       16
`define QBC_BURST_W     72
`define QBC_FIFO_DEPTH  16
`define QBC_FIFO_AW     4
`define QBC_HIST_W      5
`define QBC_TERM_OFF    2'h0

`define QBC_W_IDLE      5'h01
`define QBC_W_B0        5'h02
`define QBC_W_B1        5'h04
`define QBC_W_B2        5'h08
`define QBC_W_B3        5'h10

`endif

// file: rtl/qbc_command_port.v
// Purpose: Command decode, burst beat sequencing and read bus idling of the port.
// Assumes: Master clock, strobe and all pins are slow and sampled by i_mclk.
// Notes:   Write bursts pass a FIFO before they reach the flip-flop array.
`timescale 1ns/100ps
`include "qbc_defines.vh"

module qbc_sync #(
    parameter W = 1
) (
    input  wire         i_mclk,
    input  wire         i_sys_rst,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

module qbc_fifo #(
    parameter W     = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         i_mclk,
    input  wire         i_sys_rst,
    input  wire         i_in_valid,
    output wire         o_in_ready,
    input  wire [W-1:0] i_in_data,
    output wire         o_out_valid,
    input  wire         i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] store_q [0:DEPTH-1];
    reg [AW-1:0] wptr_q;
    reg [AW-1:0] rptr_q;
    reg [AW:0]   count_q;
    wire         do_push;
    wire         do_pop;

    assign o_in_ready  = (count_q != DEPTH[AW:0]);
    assign o_out_valid = (count_q != {(AW+1){1'b0}});
    assign o_out_data  = store_q[rptr_q];
    assign do_push     = i_in_valid & o_in_ready;
    assign do_pop      = o_out_valid & i_out_ready;

    always @(posedge i_mclk) begin
        if (do_push) begin
            store_q[wptr_q] <= i_in_data;
        end
    end

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wptr_q  <= {AW{1'b0}};
            rptr_q  <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (do_pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (do_push & ~do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop & ~do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

module qbc_command_port (
    input  wire                   i_mclk,
    input  wire                   i_sys_rst,
    input  wire                   i_master_clk,
    input  wire                   i_fetch_command_n,
    input  wire                   i_store_command_n,
    input  wire [`QBC_LOC_W-1:0]  i_location_bus,
    input  wire                   i_inbound_strobe,
    input  wire [`QBC_DATA_W-1:0] i_input_beat,
    input  wire [1:0]             i_data_termination_sel,
    output reg                    o_echo_clk,
    output reg                    o_echo_clk_n,
    output reg  [`QBC_DATA_W-1:0] o_output_beat,
    output reg                    o_output_beat_oe_n,
    output reg                    o_output_valid,
    output reg                    o_store_backpressure
);
    localparam SW = 3 + `QBC_LOC_W + 1 + `QBC_DATA_W + 2;
    localparam FW = `QBC_LOC_W + `QBC_BURST_W;
    localparam DW = `QBC_DATA_W;

    wire [SW-1:0] raw_pins;
    wire [SW-1:0] pins_s;
    wire          mck_s;
    wire          fetch_n_s;
    wire          store_n_s;
    wire [`QBC_LOC_W-1:0] loc_s;
    wire          strb_s;
    wire [DW-1:0] beat_s;
    wire [1:0]    term_s;

    assign raw_pins = {i_master_clk, i_fetch_command_n, i_store_command_n,
                       i_location_bus, i_inbound_strobe, i_input_beat,
                       i_data_termination_sel};

    qbc_sync #(.W(SW)) u_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_d       (raw_pins),
        .o_q       (pins_s)
    );

    assign {mck_s, fetch_n_s, store_n_s} = pins_s[SW-1:SW-3];
    assign loc_s  = pins_s[DW+2+1+`QBC_LOC_W-1:DW+2+1];
    assign strb_s = pins_s[DW+2];
    assign beat_s = pins_s[DW+1:2];
    assign term_s = pins_s[1:0];

    reg  mck_d1_q;
    reg  strb_d1_q;
    wire ck_rise = mck_s & ~mck_d1_q;
    wire ck_fall = ~mck_s & mck_d1_q;
    wire st_rise = strb_s & ~strb_d1_q;
    wire st_fall = ~strb_s & strb_d1_q;

    // Command decode; a read following a taken read would collide on the bus, so it is dropped.
    reg  [`QBC_HIST_W-1:0] rd_hist_q;
    wire is_read  = ~fetch_n_s;
    wire is_write = fetch_n_s & ~store_n_s;
    wire rd_take  = is_read & ~rd_hist_q[0];
    // With both commands high neither path starts and the location is not used.

    // Write burst tracker.
    reg  [4:0]              wst_q;
    reg  [4:0]              wst_d;
    reg  [`QBC_LOC_W-1:0]   waddr_q;
    reg  [`QBC_LOC_W-1:0]   waddr_d;
    reg                     pend_q;
    reg                     pend_d;
    reg  [`QBC_LOC_W-1:0]   paddr_q;
    reg  [`QBC_LOC_W-1:0]   paddr_d;
    reg  [`QBC_BURST_W-1:0] wbeats_q;
    reg  [`QBC_BURST_W-1:0] wbeats_d;
    reg                     wdone;
    reg                     push_q;
    reg  [FW-1:0]           push_data_q;

    always @* begin
        wst_d    = wst_q;
        waddr_d  = waddr_q;
        pend_d   = pend_q;
        paddr_d  = paddr_q;
        wbeats_d = wbeats_q;
        wdone    = 1'b0;
        if (st_rise) begin
            case (wst_q)
                `QBC_W_B0: begin
                    wbeats_d[DW-1:0] = beat_s;
                    wst_d = `QBC_W_B1;
                end
                `QBC_W_B2: begin
                    wbeats_d[3*DW-1:2*DW] = beat_s;
                    wst_d = `QBC_W_B3;
                end
                default: begin
                end
            endcase
        end
        if (st_fall) begin
            case (wst_q)
                `QBC_W_B1: begin
                    wbeats_d[2*DW-1:DW] = beat_s;
                    wst_d = `QBC_W_B2;
                end
                `QBC_W_B3: begin
                    wbeats_d[4*DW-1:3*DW] = beat_s;
                    wdone = 1'b1;
                    if (pend_q) begin
                        wst_d   = `QBC_W_B0;
                        waddr_d = paddr_q;
                        pend_d  = 1'b0;
                    end else begin
                        wst_d = `QBC_W_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        if (ck_rise & is_write) begin
            if (wst_d == `QBC_W_IDLE) begin
                wst_d   = `QBC_W_B0;
                waddr_d = loc_s;
            end else if (wst_d == `QBC_W_B2 || wst_d == `QBC_W_B3) begin
                pend_d  = 1'b1;
                paddr_d = loc_s;
            end
        end
    end

    // Storage behind the FIFO; draining pauses only on master clock rise cycles, too rarely for the FIFO to fill.
    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire          drain_ready = ~ck_rise;
    reg  [`QBC_BURST_W-1:0] mem_q [0:`QBC_WORDS-1];

    qbc_fifo #(.W(FW), .DEPTH(`QBC_FIFO_DEPTH), .AW(`QBC_FIFO_AW)) u_fifo (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (push_q),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_data_q),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (drain_ready),
        .o_out_data  (fifo_out_data)
    );

    always @(posedge i_mclk) begin
        if (fifo_out_valid & drain_ready) begin
            mem_q[fifo_out_data[FW-1:`QBC_BURST_W]] <= fifo_out_data[`QBC_BURST_W-1:0];
        end
    end

    // Read pipeline: one burst stage per master cycle.
    reg [`QBC_BURST_W-1:0] rd_pipe_q [0:`QBC_HIST_W-1];
    integer k;

    wire idle_float = (term_s == `QBC_TERM_OFF);

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mck_d1_q             <= 1'b0;
            strb_d1_q            <= 1'b0;
            wst_q                <= `QBC_W_IDLE;
            waddr_q              <= {`QBC_LOC_W{1'b0}};
            pend_q               <= 1'b0;
            paddr_q              <= {`QBC_LOC_W{1'b0}};
            wbeats_q             <= {`QBC_BURST_W{1'b0}};
            push_q               <= 1'b0;
            push_data_q          <= {FW{1'b0}};
            rd_hist_q            <= {`QBC_HIST_W{1'b0}};
            for (k = 0; k < `QBC_HIST_W; k = k + 1) begin
                rd_pipe_q[k] <= {`QBC_BURST_W{1'b0}};
            end
            o_echo_clk           <= 1'b0;
            o_echo_clk_n         <= 1'b1;
            o_output_beat        <= {DW{1'b0}};
            o_output_beat_oe_n   <= 1'b1;
            o_output_valid       <= 1'b0;
            o_store_backpressure <= 1'b0;
        end else begin
            mck_d1_q             <= mck_s;
            strb_d1_q            <= strb_s;
            wst_q                <= wst_d;
            waddr_q              <= waddr_d;
            pend_q               <= pend_d;
            paddr_q              <= paddr_d;
            wbeats_q             <= wbeats_d;
            push_q               <= wdone;
            push_data_q          <= {waddr_q, wbeats_d};
            o_store_backpressure <= ~fifo_in_ready;
            // Echo clock follows the sampled master clock with the same delay as the data.
            o_echo_clk           <= mck_s;
            o_echo_clk_n         <= ~mck_s;
            if (ck_rise) begin
                rd_hist_q    <= {rd_hist_q[`QBC_HIST_W-2:0], rd_take};
                rd_pipe_q[0] <= rd_take ? mem_q[loc_s] : {`QBC_BURST_W{1'b0}};
                for (k = 1; k < `QBC_HIST_W; k = k + 1) begin
                    rd_pipe_q[k] <= rd_pipe_q[k-1];
                end
                if (rd_hist_q[2]) begin
                    o_output_beat      <= rd_pipe_q[2][DW-1:0];
                    o_output_beat_oe_n <= 1'b0;
                end else if (rd_hist_q[3]) begin
                    o_output_beat      <= rd_pipe_q[3][3*DW-1:2*DW];
                    o_output_beat_oe_n <= 1'b0;
                end else begin
                    o_output_beat      <= {DW{1'b0}};
                    o_output_beat_oe_n <= idle_float;
                end
            end else if (ck_fall) begin
                o_output_valid <= rd_hist_q[3] | rd_hist_q[4];
                if (rd_hist_q[3]) begin
                    o_output_beat      <= rd_pipe_q[3][2*DW-1:DW];
                    o_output_beat_oe_n <= 1'b0;
                end else if (rd_hist_q[4]) begin
                    o_output_beat      <= rd_pipe_q[4][4*DW-1:3*DW];
                    o_output_beat_oe_n <= 1'b0;
                end else begin
                    o_output_beat      <= {DW{1'b0}};
                    o_output_beat_oe_n <= idle_float;
                end
            end
        end
    end
endmodule

// file: bench/qbc_ctrl_model.sv
// Purpose: Controller model driving commands, strobe and write beats.
// Assumes: Master clock pin period of eight i_mclk cycles.
// Notes:   Idle data lines toggle so a stale beat is never mistaken for a good one.
`timescale 1ns/100ps
`include "qbc_defines.vh"
module qbc_ctrl_model (
    input  wire                    i_mclk,
    input  wire                    i_sys_rst,
    output logic                   o_master_clk,
    output logic                   o_fetch_command_n,
    output logic                   o_store_command_n,
    output logic [`QBC_LOC_W-1:0]  o_location_bus,
    output logic                   o_inbound_strobe,
    output logic [`QBC_DATA_W-1:0] o_input_beat
);
    logic [77:0] cq [$];
    logic [77:0] wr [4] = '{default: 78'h0};
    logic [77:0] e = 78'h0;
    logic [2:0]  ph = 3'h7;
    int          cyc = 8;
    int          n;
    int          k;
    always @(negedge i_mclk) begin
        ph = ph + 3'h1;
        if (ph == 3'h0) begin
            cyc++;
        end
        o_master_clk = ph < 3'h4;
        o_inbound_strobe = ph < 3'h4;
        if (ph == 3'h4 || i_sys_rst) begin
            e = (i_sys_rst || cq.size() == 0) ? 78'h0 : cq.pop_front();
            o_fetch_command_n = e[77:76] != 2'h2;
            o_store_command_n = e[77:76] != 2'h1;
            o_location_bus = e[75:72];
            wr[(cyc + 1) % 4] = e;
        end
        if (i_sys_rst) begin
            o_input_beat = 18'h0;
        end else if (ph == 3'h3 || ph == 3'h7) begin
            n = ph == 3'h7 ? cyc : cyc - 1;
            k = ph == 3'h7 ? 0 : 1;
            if (wr[n % 4][77:76] == 2'h1) begin
                o_input_beat = wr[n % 4][k * 18 +: 18];
            end else if (wr[(n - 1) % 4][77:76] == 2'h1) begin
                o_input_beat = wr[(n - 1) % 4][(k + 2) * 18 +: 18];
            end else begin
                o_input_beat = ~o_input_beat;
            end
        end
    end
endmodule

// file: bench/qbc_command_port_chk.sv
// Purpose: Read side timing checks of the command port.
// Assumes: Outputs follow a master clock pin edge by about three i_mclk.
// Notes:   Windows allow for the pin synchroniser delay.
`timescale 1ns/100ps
`include "qbc_defines.vh"
module qbc_command_port_chk (
    input logic                   i_mclk,
    input logic                   i_sys_rst,
    input logic                   i_master_clk,
    input logic                   i_fetch_command_n,
    input logic [1:0]             i_data_termination_sel,
    input logic                   o_echo_clk,
    input logic                   o_echo_clk_n,
    input logic [`QBC_DATA_W-1:0] o_output_beat,
    input logic                   o_output_beat_oe_n,
    input logic                   o_output_valid
);
    logic m_q;
    logic rd_q;
    logic rise;
    assign rise = i_master_clk & ~m_q;
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            m_q  <= 1'h1;
            rd_q <= 1'h0;
        end else begin
            m_q <= i_master_clk;
            if (rise) begin
                rd_q <= ~i_fetch_command_n;
            end
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    chk_echo_pair: assert property (o_echo_clk_n == ~o_echo_clk)
        else $error("echo pair out of step");
    chk_beat_edge: assert property ($changed(o_output_beat) |-> $changed(o_echo_clk))
        else $error("beat moved off an echo edge");
    chk_valid_drv: assert property ($changed(o_output_valid) |-> $fell(o_echo_clk)
        && (!o_output_valid || !o_output_beat_oe_n)) else $error("valid moved off a fall edge");
    chk_read_first: assert property (rise && !i_fetch_command_n |-> ##[26:28]
        (o_echo_clk && !o_output_beat_oe_n)) else $error("first read beat late");
    chk_read_second: assert property (rise && !i_fetch_command_n |-> ##[31:33]
        o_output_valid) else $error("second read beat not valid");
    chk_read_tail: assert property (rise && i_fetch_command_n && rd_q |-> ##[26:28]
        (o_echo_clk && !o_output_beat_oe_n)) else $error("read tail not driven");
    chk_idle_float: assert property (rise && i_fetch_command_n && !rd_q
        && i_data_termination_sel == `QBC_TERM_OFF |-> ##[26:28] (o_echo_clk && o_output_beat_oe_n))
        else $error("idle slot not floated");
    chk_idle_low: assert property (rise && i_fetch_command_n && !rd_q
        && i_data_termination_sel != `QBC_TERM_OFF |-> ##[26:28]
        (o_echo_clk && !o_output_beat_oe_n && o_output_beat == 18'h0)) else $error("idle not low");
    cover property (rise && !i_fetch_command_n);
    cover property (rise && i_fetch_command_n && rd_q);
    cover property (o_output_valid);
endmodule
bind qbc_command_port qbc_command_port_chk qbc_command_port_chk_i (
    .i_mclk                 (i_mclk),
    .i_sys_rst              (i_sys_rst),
    .i_master_clk           (i_master_clk),
    .i_fetch_command_n      (i_fetch_command_n),
    .i_data_termination_sel (i_data_termination_sel),
    .o_echo_clk             (o_echo_clk),
    .o_echo_clk_n           (o_echo_clk_n),
    .o_output_beat          (o_output_beat),
    .o_output_beat_oe_n     (o_output_beat_oe_n),
    .o_output_valid         (o_output_valid)
);

// file: bench/qbc_command_port_tb.sv
// Purpose: Self-checking bench for the burst-of-four command port.
// Assumes: Outputs settle three i_mclk after each master clock pin edge.
// Notes:   Reads stay away from fresh writes, as the port has no bypass.
`timescale 1ns/100ps
`include "qbc_defines.vh"
module qbc_command_port_tb;
    logic                    i_mclk = 1'h0;
    logic                    i_sys_rst = 1'h1;
    logic [1:0]              i_data_termination_sel = 2'h0;
    wire                     i_master_clk, i_fetch_command_n, i_store_command_n, i_inbound_strobe;
    wire [`QBC_LOC_W-1:0]    i_location_bus;
    wire [`QBC_DATA_W-1:0]   i_input_beat, o_output_beat;
    wire                     o_echo_clk, o_echo_clk_n, o_output_beat_oe_n, o_output_valid;
    wire                     o_store_backpressure;
    logic [`QBC_BURST_W-1:0] mem [16];
    logic [`QBC_BURST_W-1:0] rd [8];
    logic [`QBC_BURST_W-1:0] wq [$];
    int                      kind [8] = '{default: 0};
    int                      wt [16];
    int                      num_errors = 0, cmp_count = 0, c = 8, s, k, l, last, j;
    logic                    chk_on = 1'h0, ev, eo, vv;
    always #50 i_mclk = ~i_mclk;
    qbc_ctrl_model qbc_ctrl_model_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .o_master_clk(i_master_clk), .o_fetch_command_n(i_fetch_command_n),
        .o_store_command_n(i_store_command_n), .o_location_bus(i_location_bus),
        .o_inbound_strobe(i_inbound_strobe), .o_input_beat(i_input_beat));
    qbc_command_port qbc_command_port_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_master_clk(i_master_clk), .i_fetch_command_n(i_fetch_command_n),
        .i_store_command_n(i_store_command_n), .i_location_bus(i_location_bus),
        .i_inbound_strobe(i_inbound_strobe), .i_input_beat(i_input_beat),
        .i_data_termination_sel(i_data_termination_sel), .o_echo_clk(o_echo_clk),
        .o_echo_clk_n(o_echo_clk_n), .o_output_beat(o_output_beat),
        .o_output_beat_oe_n(o_output_beat_oe_n), .o_output_valid(o_output_valid),
        .o_store_backpressure(o_store_backpressure));
    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] v);
        cmp_count++;
        if (v !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic issue(input int kd, input int loc);
        logic [71:0] d;
        d = {$urandom, $urandom, $urandom};
        if (kd == 1) begin
            wq.push_back(d);
        end
        qbc_ctrl_model_i.cq.push_back({kd[1:0], loc[3:0], d});
    endtask
    always @(i_master_clk) begin
        if (i_master_clk) begin
            c++;
            kind[c % 8] = !i_fetch_command_n ? 2 : !i_store_command_n ? 1 : 0;
            if (kind[c % 8] == 2) begin
                rd[c % 8] = mem[i_location_bus];
            end else if (kind[c % 8] == 1) begin
                mem[i_location_bus] = wq.pop_front();
            end
        end
        #375;
        if (chk_on) begin
            ev = !i_master_clk;
            s = kind[(c - 3) % 8] == 2 ? 0 : kind[(c - 4) % 8] == 2 ? 2 : -1;
            eo = s < 0 && i_data_termination_sel == `QBC_TERM_OFF;
            chk("oe_n", eo, o_output_beat_oe_n);
            // Valid only moves on a falling half, so it holds through the following rise half.
            vv = kind[(c - 4) % 8] == 2 || kind[(ev ? c - 3 : c - 5) % 8] == 2;
            chk("valid", vv, o_output_valid);
            chk("backpressure", 18'h0, o_store_backpressure);
            if (!eo) begin
                chk("beat", s < 0 ? 18'h0 : rd[(c - 3 - s / 2) % 8][(s + ev) * 18 +: 18], o_output_beat);
            end
        end
    end
    initial begin
        void'($urandom(88));
        for (int t = 0; t < 3; t++) begin
            chk_on = 1'h0;
            i_sys_rst = 1'h1;
            i_data_termination_sel = t[1:0];
            repeat (20) @(negedge i_mclk);
            i_sys_rst = 1'h0;
            repeat (48) @(negedge i_mclk);
            chk_on = 1'h1;
            for (int i = 0; i < 16; i++) begin
                issue(1, i);
                issue(i >= 3 ? 2 : 0, i - 3);
                wt[i] = 2 * i;
            end
            last = 2;
            for (int i = 32; i < 100; i++) begin
                k = $urandom % 3;
                l = $urandom % 16;
                if ((k == last && k != 0) || (k == 2 && i - wt[l] < 8)) begin
                    k = 0;
                end
                if (k == 1) begin
                    wt[l] = i;
                end
                issue(k, l);
                last = k;
            end
            for (j = 0; j < 4000 && qbc_ctrl_model_i.cq.size() != 0; j++) begin
                @(negedge i_mclk);
            end
            if (qbc_ctrl_model_i.cq.size() != 0) begin
                num_errors++;
                $display("wrong value cmd_queue expected 0 seen %0d", qbc_ctrl_model_i.cq.size());
                break;
            end
            repeat (48) @(negedge i_mclk);
        end
        complete_run;
    end
endmodule
